// >>> logic/spvr_port_policy.sv
`timescale 1ns/1ns

module spvr_port_policy (
	input	wire logic		sys_clk,	// Core clock, 250 MHz
	input	wire logic		resetn,	// Async reset, active low
	input	wire logic [7:0]	regAddr,	// Register byte offset
	input	wire logic [15:0]	regWrData,	// Write data
	input	wire logic		regWr,	// Write strobe
	input	wire logic		regRd,	// Read strobe
	output	logic [15:0]		regRdData,	// Read data, cycle after strobe
	input	wire logic		anegPause,	// Negotiated flow control result
	input	wire logic		halfDuplex,	// Link is half duplex
	input	wire logic		congested,	// Queue wants back pressure
	output	logic			flowCtrlOn,	// Flow control in effect
	output	logic			backPressOn,	// Back pressure in effect
	input	wire logic		ingValid,	// Ingress frame header present
	input	wire logic		ingTagged,	// Frame carried a tag
	input	wire logic [11:0]	ingVid,	// Frame VID
	input	wire logic [2:0]	ingPrio,	// Frame priority
	input	wire logic [2:0]	ingVlanMembers,	// VLAN table members of VID
	input	wire logic [2:0]	ingDestMask,	// Lookup destination ports
	input	wire logic		ingBcast,	// Broadcast frame
	input	wire logic		ingMcast,	// Multicast frame
	input	wire logic		ingFlood,	// Unknown unicast, flooded
	input	wire logic [10:0]	ingLen,	// Frame length in bytes
	output	logic			ingDone,	// Ingress verdict pulse
	output	logic			ingDrop,	// Frame is discarded
	output	logic [11:0]		ingVidOut,	// Classified VID
	output	logic [2:0]		ingPrioOut,	// Priority after ceiling
	output	logic [2:0]		ingFwdMask,	// Allowed destination ports
	output	logic			ingMonitor,	// Copy to mirror destination
	output	logic			ingLearn,	// Learn source address
	output	logic			ingCounted,	// Frame counts against limit
	output	logic [11:0]		ingRateBytes,	// Bytes charged to rate
	input	wire logic		egValid,	// Egress frame offered
	input	wire logic		egTagged,	// Frame arrived tagged
	input	wire logic		egMonitored,	// Frame is marked monitored
	input	wire logic		egInsertEn,	// Tag insertion active
	input	wire logic [15:0]	egSrcTag,	// Ingress port default tag
	input	wire logic [10:0]	egLen,	// Frame length in bytes
	output	logic			egDone,	// Egress verdict pulse
	output	logic			egSend,	// Frame may be sent
	output	logic			egAddTag,	// Insert a tag
	output	logic [15:0]		egTag,	// Tag to insert
	output	logic			egMirror,	// Copy to mirror destination
	output	logic [11:0]		egRateBytes	// Bytes charged to rate
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic	rstSync1_reg;
	logic	rstn;

	// Two stages so the release is clean against sys_clk
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rstSync1_reg <= 1'h0;
			rstn         <= 1'h0;
		end else begin
			rstSync1_reg <= 1'h1;
			rstn         <= rstSync1_reg;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [15:0]	policy_reg;
	logic [15:0]	tag_reg;
	logic [15:0]	rate_reg;
	logic [15:0]	dropCnt_reg;
	logic [15:0]	rdData_next;
	logic		wrPolicy;
	logic		wrTag;
	logic		wrRate;

	assign wrPolicy = regWr && (regAddr == spvr_pkg::OFS_POLICY);
	assign wrTag    = regWr && (regAddr == spvr_pkg::OFS_TAG);
	assign wrRate   = regWr && (regAddr == spvr_pkg::OFS_RATE);

	// Reserved bits of the policy register are plain storage
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			policy_reg <= spvr_pkg::POLICY_RST;
		end else if (wrPolicy) begin
			policy_reg <= regWrData;
		end
	end

	// Default tag, whole word
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tag_reg <= spvr_pkg::TAG_RST;
		end else if (wrTag) begin
			tag_reg <= regWrData;
		end
	end

	// Upper bits are not stored at all, so they cannot read back
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rate_reg <= spvr_pkg::RATE_RST;
		end else if (wrRate) begin
			rate_reg <= regWrData & spvr_pkg::RATE_RW_MASK;
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		case (regAddr)
			spvr_pkg::OFS_POLICY: rdData_next = policy_reg;
			spvr_pkg::OFS_TAG:    rdData_next = tag_reg;
			spvr_pkg::OFS_RATE:   rdData_next = rate_reg;
			spvr_pkg::OFS_STATUS: rdData_next = dropCnt_reg;
			default:              rdData_next = 16'h0000;
		endcase
	end

	// Data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			regRdData <= 16'h0000;
		end else begin
			regRdData <= regRd ? rdData_next : 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// Field views
	// ------------------------------------------------------------
	logic [2:0]		membership;
	logic [11:0]		portVid;
	logic [2:0]		userPrio;
	spvr_pkg::spvr_limit_e	limMode;
	logic [11:0]		extraBytes;

	assign membership = policy_reg[spvr_pkg::MEMB_MSB:spvr_pkg::MEMB_LSB];
	assign portVid    = tag_reg[spvr_pkg::TAG_VID_MSB:0];
	assign userPrio   = tag_reg[spvr_pkg::TAG_PRIO_MSB:spvr_pkg::TAG_PRIO_LSB];
	assign limMode    = spvr_pkg::spvr_limit_e'(
		rate_reg[spvr_pkg::RATE_MODE_MSB:spvr_pkg::RATE_MODE_LSB]);
	// Overhead bytes shared by ingress and egress rate figures
	assign extraBytes =
		(rate_reg[spvr_pkg::BIT_RATE_IFG] ? spvr_pkg::IFG_BYTES : 12'h000)
		+ (rate_reg[spvr_pkg::BIT_RATE_PRE] ? spvr_pkg::PRE_BYTES : 12'h000);

	// ------------------------------------------------------------
	// Port level controls
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			flowCtrlOn <= 1'h0;
		end else begin
			flowCtrlOn <= policy_reg[spvr_pkg::BIT_FORCE_FC] | anegPause;
		end
	end

	// Back pressure is a half-duplex mechanism only
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			backPressOn <= 1'h0;
		end else begin
			backPressOn <= policy_reg[spvr_pkg::BIT_BACK_PRES]
				& halfDuplex & congested;
		end
	end

	// ------------------------------------------------------------
	// Ingress verdict
	// ------------------------------------------------------------
	logic [11:0]	effVid;
	logic [2:0]	basePrio;
	logic		dropVlan;
	logic		dropPvid;
	logic		dropAny;
	logic		counted;
	logic [2:0]	fwdMask;

	// Untagged and null-VID frames take the port default VID
	assign effVid = (!ingTagged || ingVid == 12'h000) ? portVid : ingVid;
	assign basePrio = ingTagged ? ingPrio : userPrio;
	assign dropVlan = policy_reg[spvr_pkg::BIT_VLAN_FILT]
		& ~ingVlanMembers[spvr_pkg::PORT_SELF];
	assign dropPvid = policy_reg[spvr_pkg::BIT_NON_PORT_DEFAULT_VLAN_ID] & (effVid != portVid);
	assign dropAny  = dropVlan | dropPvid | ~policy_reg[spvr_pkg::BIT_RX_EN];

	// Frame class selection for the ingress limiter
	always_comb begin
		case (limMode)
			spvr_pkg::LIM_ALL:   counted = 1'h1;
			spvr_pkg::LIM_FLOOD: counted = ingBcast | ingMcast | ingFlood;
			spvr_pkg::LIM_BCMC:  counted = ingBcast | ingMcast;
			spvr_pkg::LIM_BC:    counted = ingBcast;
			default:             counted = 1'h1;
		endcase
	end

	// One gate per destination port
	for (genvar p = 0; p < 3; p++) begin : g_memb
		assign fwdMask[p] = ingDestMask[p] & membership[p];
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ingDone <= 1'h0;
			ingDrop <= 1'h0;
		end else begin
			ingDone <= ingValid;
			ingDrop <= ingValid & dropAny;
		end
	end

	// Frame attributes, held until the next frame
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ingVidOut    <= 12'h000;
			ingPrioOut   <= 3'h0;
			ingFwdMask   <= 3'h0;
			ingMonitor   <= 1'h0;
			ingLearn     <= 1'h0;
			ingCounted   <= 1'h0;
			ingRateBytes <= 12'h000;
		end else if (ingValid) begin
			ingVidOut <= effVid;
			if (policy_reg[spvr_pkg::BIT_PRIO_CEIL] && basePrio > userPrio) begin
				ingPrioOut <= userPrio;
			end else begin
				ingPrioOut <= basePrio;
			end
			ingFwdMask   <= dropAny ? 3'h0 : fwdMask;
			ingMonitor   <= ~dropAny & policy_reg[spvr_pkg::BIT_RX_SNIFF];
			ingLearn     <= ~dropAny & ~policy_reg[spvr_pkg::BIT_LEARN_DIS];
			ingCounted   <= counted;
			ingRateBytes <= 12'(ingLen) + extraBytes;
		end
	end

	// Saturating count of discarded frames, visible to software
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dropCnt_reg <= 16'h0000;
		end else if (ingValid && dropAny && dropCnt_reg != 16'hFFFF) begin
			dropCnt_reg <= dropCnt_reg + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// Egress verdict
	// ------------------------------------------------------------
	logic	egOk;

	// A monitored copy only leaves through the mirror destination port
	assign egOk = policy_reg[spvr_pkg::BIT_TX_EN]
		& (~egMonitored | policy_reg[spvr_pkg::BIT_SNIFF_DEST]);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			egDone <= 1'h0;
			egSend <= 1'h0;
		end else begin
			egDone <= egValid;
			egSend <= egValid & egOk;
		end
	end

	// Tag, mirror and byte charge, held until the next frame
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			egAddTag    <= 1'h0;
			egTag       <= 16'h0000;
			egMirror    <= 1'h0;
			egRateBytes <= 12'h000;
		end else if (egValid) begin
			egAddTag    <= egInsertEn & ~egTagged;
			egTag       <= egSrcTag;
			egMirror    <= egOk & policy_reg[spvr_pkg::BIT_TX_SNIFF];
			egRateBytes <= 12'(egLen) + extraBytes;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence s_tagWr;
		regWr && regAddr == spvr_pkg::OFS_TAG;
	endsequence
	sequence s_tagRd;
		regRd && regAddr == spvr_pkg::OFS_TAG;
	endsequence

	property p_vlanFilt;
		ingValid && policy_reg[spvr_pkg::BIT_VLAN_FILT] && !ingVlanMembers[0]
			|=> ingDone && ingDrop && ingFwdMask == 3'h0;
	endproperty
	a_vlanFilt: assert property (p_vlanFilt)
		else $error("filtered frame not dropped");

	property p_nonPvid;
		ingValid && ingTagged && ingVid != 12'h000 && ingVid != portVid
			&& policy_reg[spvr_pkg::BIT_NON_PORT_DEFAULT_VLAN_ID] |=> ingDrop;
	endproperty
	a_nonPvid: assert property (p_nonPvid)
		else $error("non default VID frame not dropped");

	property p_forceFc;
		policy_reg[spvr_pkg::BIT_FORCE_FC] |=> flowCtrlOn;
	endproperty
	a_forceFc: assert property (p_forceFc)
		else $error("forced flow control off");

	property p_backPres;
		backPressOn |-> $past(policy_reg[spvr_pkg::BIT_BACK_PRES]) && $past(halfDuplex);
	endproperty
	a_backPres: assert property (p_backPres)
		else $error("back pressure without enable");

	property p_txGate;
		egValid && !policy_reg[spvr_pkg::BIT_TX_EN] |=> egDone && !egSend;
	endproperty
	a_txGate: assert property (p_txGate)
		else $error("sent while transmit disabled");

	property p_rxGate;
		ingValid && !policy_reg[spvr_pkg::BIT_RX_EN] |=> ingDrop && !ingLearn;
	endproperty
	a_rxGate: assert property (p_rxGate)
		else $error("received while receive disabled");

	property p_ceiling;
		ingDone && $past(policy_reg[spvr_pkg::BIT_PRIO_CEIL]) |-> ingPrioOut <= $past(userPrio);
	endproperty
	a_ceiling: assert property (p_ceiling)
		else $error("priority above ceiling");

	property p_member;
		ingDone |-> (ingFwdMask & ~$past(membership)) == 3'h0;
	endproperty
	a_member: assert property (p_member)
		else $error("forward outside membership");

	property p_tagBack;
		s_tagWr ##1 (s_tagRd and !regWr) |=> regRdData == $past(regWrData, 2);
	endproperty
	a_tagBack: assert property (p_tagBack)
		else $error("default tag readback wrong");

	property p_rateRsv;
		regRd && regAddr == spvr_pkg::OFS_RATE |=> regRdData[15:5] == 11'h000;
	endproperty
	a_rateRsv: assert property (p_rateRsv)
		else $error("reserved rate bits nonzero");

endmodule // spvr_port_policy

// >>> shared/spvr_pkg.sv
package spvr_pkg;

	// ------------------------------------------------------------
	// Register port geometry and offsets
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [7:0] OFS_POLICY = 8'h6E;
	localparam logic [7:0] OFS_TAG    = 8'h70;
	localparam logic [7:0] OFS_RATE   = 8'h72;
	localparam logic [7:0] OFS_STATUS = 8'hFE;

	// ------------------------------------------------------------
	// Forwarding policy fields
	// ------------------------------------------------------------
	localparam int BIT_VLAN_FILT  = 14;
	localparam int BIT_NON_PORT_DEFAULT_VLAN_ID   = 13;
	localparam int BIT_FORCE_FC   = 12;
	localparam int BIT_BACK_PRES  = 11;
	localparam int BIT_TX_EN      = 10;
	localparam int BIT_RX_EN      = 9;
	localparam int BIT_LEARN_DIS  = 8;
	localparam int BIT_SNIFF_DEST = 7;
	localparam int BIT_RX_SNIFF   = 6;
	localparam int BIT_TX_SNIFF   = 5;
	localparam int BIT_PRIO_CEIL  = 3;
	localparam int MEMB_LSB       = 0;
	localparam int MEMB_MSB       = 2;
	localparam int PORT_SELF      = 0;	// This port is the first network port

	// ------------------------------------------------------------
	// Default tag and rate option fields
	// ------------------------------------------------------------
	localparam int TAG_PRIO_LSB  = 13;
	localparam int TAG_PRIO_MSB  = 15;
	localparam int TAG_VID_MSB   = 11;
	localparam int RATE_MODE_LSB = 2;
	localparam int RATE_MODE_MSB = 3;
	localparam int BIT_RATE_IFG  = 1;
	localparam int BIT_RATE_PRE  = 0;
	localparam logic [15:0] RATE_RW_MASK = 16'h001F;

	// ------------------------------------------------------------
	// Reset values and byte counts
	// ------------------------------------------------------------
	localparam logic [15:0] POLICY_RST = 16'h0607;
	localparam logic [15:0] TAG_RST    = 16'h0001;
	localparam logic [15:0] RATE_RST   = 16'h0000;
	localparam logic [11:0] IFG_BYTES  = 12'h00C;
	localparam logic [11:0] PRE_BYTES  = 12'h008;

	typedef enum logic [1:0] {
		LIM_ALL   = 2'b00,
		LIM_FLOOD = 2'b01,
		LIM_BCMC  = 2'b10,
		LIM_BC    = 2'b11
	} spvr_limit_e;

endpackage

// >>> verif/switch_port_vlan_rate_ctrl_tb.sv
`timescale 1ns/1ns
module switch_port_vlan_rate_ctrl_tb;

	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic sys_clk = 0, resetn = 0, regWr = 0, regRd = 0;
	logic [7:0] regAddr = 0;
	logic [15:0] regWrData = 0, regRdData, egSrcTag = 0, egTag;
	logic anegPause = 0, halfDuplex = 0, congested = 0, flowCtrlOn, backPressOn;
	logic ingValid = 0, ingTagged = 0, ingBcast = 0, ingMcast = 0, ingFlood = 0;
	logic [11:0] ingVid = 0, ingVidOut, ingRateBytes, egRateBytes;
	logic [2:0] ingPrio = 0, ingVlanMembers = 0, ingDestMask = 0, ingPrioOut, ingFwdMask;
	logic [10:0] ingLen = 0, egLen = 0;
	logic ingDone, ingDrop, ingMonitor, ingLearn, ingCounted;
	logic egValid = 0, egTagged = 0, egMonitored = 0, egInsertEn = 0;
	logic egDone, egSend, egAddTag, egMirror;
	logic [15:0] polVal, tagVal, rateVal;
	integer seed = 51805, errors = 0, comparisons = 0, cycles = 0, drops = 0;

	spvr_port_policy uut (.*);

	// Free-running core clock, 4 ns period
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Hang guard, generous against a run of about two thousand cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			close_out();
		end
	end

	// ------------------------------------------------------------
	// Register port master: one-cycle strobes, data in next cycle
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask

	// Write then read with no gap; the read must already see the new word
	task automatic wr_rd(input logic [7:0] a, input logic [15:0] wd, output logic [15:0] d);
		@(posedge sys_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= wd;
		@(posedge sys_clk);
		regWr <= 1'b0;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask

	// ------------------------------------------------------------
	// Frame and link drivers with their expectations
	// ------------------------------------------------------------
	task automatic ing_frame();
		logic [31:0] r;
		logic [11:0] vid;
		logic [2:0] p;
		logic drop, cnt;
		r = $random(seed);
		vid = (r[1:0] == 0) ? 12'h000 : (r[1:0] == 1) ? tagVal[11:0] : r[31:20];
		@(posedge sys_clk);
		ingValid <= 1'b1;
		ingTagged <= r[2];
		ingVid <= vid;
		ingPrio <= r[5:3];
		ingVlanMembers <= r[8:6];
		ingDestMask <= r[11:9];
		{ingBcast, ingMcast, ingFlood} <= r[14:12];
		ingLen <= r[25:15];
		// Null VID and untagged frames both fall back to the default VID
		if (!r[2] || vid == 0) vid = tagVal[11:0];
		drop = !polVal[spvr_pkg::BIT_RX_EN]
			|| (polVal[spvr_pkg::BIT_VLAN_FILT] && !r[6])
			|| (polVal[spvr_pkg::BIT_NON_PORT_DEFAULT_VLAN_ID] && vid != tagVal[11:0]);
		// Running total of discards, compared with the status counter later
		if (drop) drops++;
		p = r[2] ? r[5:3] : tagVal[15:13];
		if (polVal[spvr_pkg::BIT_PRIO_CEIL] && p > tagVal[15:13]) p = tagVal[15:13];
		case (rateVal[3:2])
			2'b00: cnt = 1'b1;
			2'b01: cnt = |r[14:12];
			2'b10: cnt = |r[14:13];
			default: cnt = r[14];
		endcase
		@(posedge sys_clk);
		ingValid <= 1'b0;
		#1;
		chk(ingDone, 1'b1);
		chk(ingDrop, drop);
		chk(ingVidOut, vid);
		chk(ingPrioOut, p);
		chk(ingFwdMask, drop ? 3'h0 : r[11:9] & polVal[2:0]);
		chk(ingMonitor, !drop && polVal[spvr_pkg::BIT_RX_SNIFF]);
		chk(ingLearn, !drop && !polVal[spvr_pkg::BIT_LEARN_DIS]);
		chk(ingCounted, cnt);
		chk(ingRateBytes, 12'(r[25:15]) + (rateVal[1] ? 12'h00C : 12'h000)
			+ (rateVal[0] ? 12'h008 : 12'h000));
	endtask

	task automatic eg_frame();
		logic [31:0] r;
		logic ok;
		r = $random(seed);
		ok = polVal[spvr_pkg::BIT_TX_EN] && !(r[1] && !polVal[spvr_pkg::BIT_SNIFF_DEST]);
		@(posedge sys_clk);
		egValid <= 1'b1;
		{egTagged, egMonitored, egInsertEn} <= r[2:0];
		egSrcTag <= r[31:16];
		egLen <= r[13:3];
		@(posedge sys_clk);
		egValid <= 1'b0;
		#1;
		chk(egDone, 1'b1);
		chk(egSend, ok);
		chk(egAddTag, r[0] && !r[2]);
		chk(egTag, r[31:16]);
		chk(egMirror, ok && polVal[spvr_pkg::BIT_TX_SNIFF]);
		chk(egRateBytes, 12'(r[13:3]) + (rateVal[1] ? 12'h00C : 12'h000)
			+ (rateVal[0] ? 12'h008 : 12'h000));
	endtask

	task automatic link_step();
		logic [31:0] r;
		r = $random(seed);
		@(posedge sys_clk);
		{anegPause, halfDuplex, congested} <= r[2:0];
		@(posedge sys_clk);
		#1;
		chk(flowCtrlOn, polVal[spvr_pkg::BIT_FORCE_FC] | r[2]);
		chk(backPressOn, polVal[spvr_pkg::BIT_BACK_PRES] & r[1] & r[0]);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [15:0] d;
		logic [31:0] r;
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);

		// An unmapped write that must leave everything alone, then the reset values
		wr(8'h00, 16'hFFFF);
		rd(spvr_pkg::OFS_POLICY, d);
		chk(d, 16'h0607);
		rd(spvr_pkg::OFS_TAG, d);
		chk(d, 16'h0001);
		rd(spvr_pkg::OFS_RATE, d);
		chk(d, 16'h0000);
		rd(8'h00, d);
		chk(d, 16'h0000);
		// Status counter is read only: a write must not disturb it
		wr(spvr_pkg::OFS_STATUS, 16'hFFFF);
		rd(spvr_pkg::OFS_STATUS, d);
		chk(d, 16'h0000);
		$display("Test reset values done");

		// Random register traffic, read straight back
		for (int i = 0; i < 20; i++) begin
			r = $random(seed);
			wr(spvr_pkg::OFS_POLICY, r[15:0]);
			rd(spvr_pkg::OFS_POLICY, d);
			chk(d & 16'h7FEF, r[15:0] & 16'h7FEF);
			wr_rd(spvr_pkg::OFS_TAG, r[31:16], d);
			chk(d, r[31:16]);
			wr(spvr_pkg::OFS_RATE, r[31:16] ^ r[15:0]);
			rd(spvr_pkg::OFS_RATE, d);
			chk(d, (r[31:16] ^ r[15:0]) & 16'h001F);
		end
		$display("Test register access done");

		// Frames under shifting policy; every limit mode is visited
		for (int i = 0; i < 240; i++) begin
			if (i % 6 == 0) begin
				r = $random(seed);
				polVal = r[15:0];
				tagVal = r[31:16];
				rateVal = {11'h000, 1'b0, 2'((i / 6) % 4), r[17:16]};
				wr(spvr_pkg::OFS_POLICY, polVal);
				wr(spvr_pkg::OFS_TAG, tagVal);
				wr(spvr_pkg::OFS_RATE, {r[31:20], rateVal[3:0]});
			end
			ing_frame();
			eg_frame();
			link_step();
		end
		rd(spvr_pkg::OFS_STATUS, d);
		chk(d, drops[15:0]);
		$display("Test frame policy done");
		close_out();
	end

endmodule // switch_port_vlan_rate_ctrl_tb
